// [inc/sensor_bringup_pkg.sv]
// constants, carriers and states shared by the sensor bring-up design
`default_nettype none
package sensor_bringup_pkg;
    localparam int NUM_SLOTS_DEF = 2;
    localparam int REF_CLK_HZ    = 25_000_000;
    localparam int CLK_PER_US    = REF_CLK_HZ / 1_000_000;
    // card must look stable this long before it is trusted
    localparam int SETTLE_MS     = 10;
    localparam int SETTLE_CYC    = REF_CLK_HZ / 1000 * SETTLE_MS;
    // half period of the start-up blink
    localparam int BLINK_MS      = 250;
    localparam int BLINK_CYC     = REF_CLK_HZ / 1000 * BLINK_MS;
    // sensor reset held after the supply comes up
    localparam int RST_HOLD_US   = 1000;
    localparam int RST_HOLD_CYC  = CLK_PER_US * RST_HOLD_US;
    // quarter bit of a 100 kHz two-wire clock, rounded up
    localparam int I2C_QTR_NS    = 2500;
    localparam int I2C_QTR_CYC   = (I2C_QTR_NS * CLK_PER_US + 999) / 1000;
    localparam logic [6:0] IDMEM_ADDR  = 7'h50;
    localparam logic [7:0] DESC_OFFSET = 8'h00;
    // accepted descriptor contents, values arbitrary
    localparam logic [7:0] BOARD_TYPE_DEF  = 8'h5a;
    localparam logic [7:0] SENSOR_TYPE_DEF = 8'h01;

    typedef struct packed {
        logic [7:0] board;
        logic [7:0] sensor;
    } desc_t;

    typedef struct packed {
        logic r;
        logic g;
        logic b;
    } rgb_t;

    localparam rgb_t RGB_OFF   = '{r: 1'b0, g: 1'b0, b: 1'b0};
    localparam rgb_t RGB_RED   = '{r: 1'b1, g: 1'b0, b: 1'b0};
    localparam rgb_t RGB_GREEN = '{r: 1'b0, g: 1'b1, b: 1'b0};
    localparam rgb_t RGB_BLUE  = '{r: 1'b0, g: 1'b0, b: 1'b1};

    // pin levels of one card slot, after synchronising
    typedef struct packed {
        logic scl;
        logic sda;
        logic lamp;
        logic irq_n;
    } slot_pins_t;

    typedef enum logic [2:0] {
        S_ABSENT, S_SETTLE, S_READ, S_ROTATED, S_REJECT, S_POWER, S_ACTIVE
    } slot_state_t;

    typedef enum logic [1:0] {
        OP_START, OP_STOP, OP_WRITE, OP_READ
    } i2c_op_t;
endpackage
`default_nettype wire

// [hdl/idmem_reader.sv]
// two-wire descriptor reader for one card identification memory
`default_nettype none
module idmem_reader
    import sensor_bringup_pkg::*;
#(
    parameter int QTR_CYCLES = I2C_QTR_CYC
) (
    input  wire logic clk,      // system clock
    input  wire logic rst_n,    // async reset, active low
    input  wire logic start,    // one-cycle read request
    input  wire logic sda_in,   // synchronised data line
    output logic      sda_oe_n, // low pulls data low
    output logic      scl_oe_n, // low pulls clock low
    output logic      done,     // one-cycle completion pulse
    output logic      err,      // an address or offset was not acked
    output desc_t     desc      // descriptor bytes read
);
    logic        busy_q;
    logic [2:0]  step_q;
    logic [3:0]  bit_q;
    logic [1:0]  ph_q;
    logic [15:0] cnt_q;
    logic [7:0]  shift_q;
    logic        sda_oe_n_q;
    logic        scl_oe_n_q;
    logic        done_q;
    logic        err_q;
    desc_t       desc_q;
    logic        tick;
    i2c_op_t     op;

    // fixed transfer: start, write pointer, restart, read two bytes, stop
    function automatic i2c_op_t op_of(input logic [2:0] s);
        unique case (s)
            3'h0, 3'h3: op_of = OP_START;
            3'h5, 3'h6: op_of = OP_READ;
            3'h7:       op_of = OP_STOP;
            default:    op_of = OP_WRITE;
        endcase
    endfunction

    function automatic logic [7:0] wr_byte(input logic [2:0] s);
        if (s == 3'h1) begin
            wr_byte = {IDMEM_ADDR, 1'b0};
        end else if (s == 3'h2) begin
            wr_byte = DESC_OFFSET;
        end else begin
            wr_byte = {IDMEM_ADDR, 1'b1};
        end
    endfunction

    assign op   = op_of(step_q);
    assign tick = busy_q && (cnt_q == 16'(QTR_CYCLES - 1));

    // quarter-bit pacing; no clock stretching is honoured
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 16'h0;
        end else if (!busy_q || tick) begin
            cnt_q <= 16'h0;
        end else begin
            cnt_q <= cnt_q + 16'h1;
        end
    end

    // bit sequencer: data set, clock high, sample, clock low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q     <= 1'b0;
            step_q     <= 3'h0;
            bit_q      <= 4'h0;
            ph_q       <= 2'h0;
            shift_q    <= 8'h00;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
            done_q     <= 1'b0;
            err_q      <= 1'b0;
            desc_q     <= '0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                busy_q  <= 1'b1;
                step_q  <= 3'h0;
                bit_q   <= 4'h0;
                ph_q    <= 2'h0;
                err_q   <= 1'b0;
            end else if (tick) begin
                ph_q <= ph_q + 2'h1;
                unique case (ph_q)
                    2'h0: begin
                        if (op == OP_START) begin
                            sda_oe_n_q <= 1'b1;
                        end else if (op == OP_STOP) begin
                            sda_oe_n_q <= 1'b0;
                        end else if (op == OP_WRITE) begin
                            sda_oe_n_q <= (bit_q == 4'h8) | shift_q[7];
                        end else begin
                            // ack first byte, nack the last
                            sda_oe_n_q <= (bit_q != 4'h8) | (step_q == 3'h6);
                        end
                    end
                    2'h1: scl_oe_n_q <= 1'b1;
                    2'h2: begin
                        if (op == OP_START) begin
                            sda_oe_n_q <= 1'b0;
                        end else if (op == OP_STOP) begin
                            sda_oe_n_q <= 1'b1;
                        end else if (op == OP_WRITE) begin
                            if (bit_q == 4'h8 && sda_in) begin
                                err_q <= 1'b1;
                            end
                        end else if (bit_q != 4'h8) begin
                            shift_q <= {shift_q[6:0], sda_in};
                        end
                    end
                    2'h3: begin
                        if (op == OP_STOP) begin
                            busy_q <= 1'b0;
                            done_q <= 1'b1;
                        end else begin
                            scl_oe_n_q <= 1'b0;
                            if (op == OP_START) begin
                                step_q  <= step_q + 3'h1;
                                shift_q <= wr_byte(step_q + 3'h1);
                            end else if (bit_q == 4'h8) begin
                                bit_q <= 4'h0;
                                if (step_q == 3'h5) begin
                                    desc_q.board <= shift_q;
                                end
                                if (step_q == 3'h6) begin
                                    desc_q.sensor <= shift_q;
                                end
                                // a missing ack cuts straight to stop
                                step_q  <= err_q ? 3'h7 : step_q + 3'h1;
                                shift_q <= wr_byte(step_q + 3'h1);
                            end else begin
                                bit_q <= bit_q + 4'h1;
                                if (op == OP_WRITE) begin
                                    shift_q <= {shift_q[6:0], 1'b0};
                                end
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign sda_oe_n = sda_oe_n_q;
    assign scl_oe_n = scl_oe_n_q;
    assign done     = done_q;
    assign err      = err_q;
    assign desc     = desc_q;
endmodule
`default_nettype wire

// [hdl/sensor_bringup_sequencer.sv]
// bring-up and supervision of the sensor card slots
`default_nettype none
module sensor_bringup_sequencer
    import sensor_bringup_pkg::*;
#(
    parameter int         NUM_SLOTS       = NUM_SLOTS_DEF,
    parameter int         SETTLE_CYCLES   = SETTLE_CYC,
    parameter int         BLINK_CYCLES    = BLINK_CYC,
    parameter int         RST_HOLD_CYCLES = RST_HOLD_CYC,
    parameter int         QTR_CYCLES      = I2C_QTR_CYC,
    parameter logic [7:0] BOARD_TYPE_OK   = BOARD_TYPE_DEF,
    parameter logic [7:0] SENSOR_TYPE_OK  = SENSOR_TYPE_DEF
) (
    input  wire logic                 REF_CLK,          // 25 MHz clock
    input  wire logic                 RESET_N,          // async, low
    input  wire logic [NUM_SLOTS-1:0] IDM_SDA_I,        // data pin level
    output wire logic [NUM_SLOTS-1:0] IDM_SDA_O,        // always low
    output wire logic [NUM_SLOTS-1:0] IDM_SDA_OE_N,     // low drives
    input  wire logic [NUM_SLOTS-1:0] IDM_SCL_I,        // clock pin level
    output wire logic [NUM_SLOTS-1:0] IDM_SCL_O,        // always low
    output wire logic [NUM_SLOTS-1:0] IDM_SCL_OE_N,     // low drives
    input  wire logic [NUM_SLOTS-1:0] CARD_LAMP_I,      // lamp pin level
    output wire logic [NUM_SLOTS-1:0] CARD_LAMP_O,      // always low
    output wire logic [NUM_SLOTS-1:0] CARD_LAMP_OE_N,   // low lights
    input  wire logic [NUM_SLOTS-1:0] SENSOR_IRQ_N,     // card irq, low
    output wire logic [NUM_SLOTS-1:0] SENSOR_IRQ,       // irq seen
    output wire logic [NUM_SLOTS-1:0] SENSOR_RST_N,     // card reset
    output wire logic [NUM_SLOTS-1:0] SENSOR_SUPPLY_EN, // sensor rails
    output wire logic [NUM_SLOTS-1:0] IDMEM_RAIL_EN,    // digital rail
    input  wire logic [NUM_SLOTS-1:0] XLAT_OVR,         // take over
    input  wire logic [NUM_SLOTS-1:0] XLAT_EN_SET,      // enable value
    input  wire logic [NUM_SLOTS-1:0] XLAT_DIR_SET,     // dir value
    output wire logic [NUM_SLOTS-1:0] XLAT_EN,          // translator en
    output wire logic [NUM_SLOTS-1:0] XLAT_DIR,         // 1: we master
    output wire logic [NUM_SLOTS-1:0] CARD_ROTATED,     // error flag
    output wire logic [NUM_SLOTS-1:0] CARD_READY,       // sensor up
    output rgb_t                      RGB_LAMP          // status lamp
);
    wire logic [NUM_SLOTS-1:0] busy_v;
    wire logic [NUM_SLOTS-1:0] rot_v;
    wire logic [NUM_SLOTS-1:0] ready_v;

    logic        boot_q;
    logic [31:0] boot_cnt_q;
    logic [31:0] blink_cnt_q;
    logic        blink_q;
    rgb_t        rgb_q;

    // one full copy of the sequence per slot
    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
        slot_pins_t  meta_q;
        slot_pins_t  pins_q;
        slot_state_t state_q;
        slot_state_t state_d;
        logic [31:0] timer_q;
        logic        supply_q;
        logic        rst_n_q;
        logic        rail_q;
        logic        lamp_oe_n_q;
        logic        low_q;
        logic        rot_q;
        logic        ready_q;
        logic        irq_q;
        logic        xen_q;
        logic        xdir_q;
        logic        rd_start_q;
        logic        rd_done;
        logic        rd_err;
        logic        sda_oe_n;
        logic        scl_oe_n;
        desc_t       rd_desc;
        logic        correct;
        logic        rotated;
        logic        absent;
        logic        desc_ok;

        // pins come from the card, two flops before use; reset reads
        // as an empty slot so no false plug-in follows it
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                meta_q <= '{irq_n: 1'b1, default: 1'b0};
                pins_q <= '{irq_n: 1'b1, default: 1'b0};
            end else begin
                meta_q <= '{scl: IDM_SCL_I[i], sda: IDM_SDA_I[i],
                            lamp: CARD_LAMP_I[i], irq_n: SENSOR_IRQ_N[i]};
                pins_q <= meta_q;
            end
        end

        // card pulls up the bus lines, or the lamp line when turned
        assign correct = pins_q.scl & pins_q.sda;
        assign rotated = pins_q.lamp & ~correct;
        assign absent  = ~correct & ~rotated;
        assign desc_ok = (rd_desc.board == BOARD_TYPE_OK) &&
                         (rd_desc.sensor == SENSOR_TYPE_OK);

        // slot sequence; removal falls back to absent from every state but read
        always_comb begin
            state_d = state_q;
            unique case (state_q)
                S_ABSENT: begin
                    if (!absent) begin
                        state_d = S_SETTLE;
                    end
                end
                S_SETTLE: begin
                    if (absent) begin
                        state_d = S_ABSENT;
                    end else if (timer_q == 32'(SETTLE_CYCLES - 1)) begin
                        state_d = correct ? S_READ : S_ROTATED;
                    end
                end
                S_READ: begin
                    // own bus traffic hides removal until the read ends
                    if (rd_done) begin
                        state_d = (!rd_err && desc_ok) ? S_POWER
                                                       : S_REJECT;
                    end
                end
                S_POWER: begin
                    if (absent) begin
                        state_d = S_ABSENT;
                    end else if (timer_q == 32'(RST_HOLD_CYCLES - 1)) begin
                        state_d = S_ACTIVE;
                    end
                end
                S_ACTIVE, S_ROTATED, S_REJECT: begin
                    if (absent) begin
                        state_d = S_ABSENT;
                    end
                end
            endcase
        end

        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                state_q <= S_ABSENT;
            end else begin
                state_q <= state_d;
            end
        end

        // dwell timer, restarted on every state change
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                timer_q <= 32'h0;
            end else if (state_d != state_q) begin
                timer_q <= 32'h0;
            end else begin
                timer_q <= timer_q + 32'h1;
            end
        end

        // descriptor read is launched once on leaving settle for read
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                rd_start_q <= 1'b0;
            end else begin
                rd_start_q <= (state_q == S_SETTLE) &&
                              (state_d == S_READ);
            end
        end

        idmem_reader #(
            .QTR_CYCLES (QTR_CYCLES)
        ) u_reader (
            .clk      (REF_CLK),
            .rst_n    (RESET_N),
            .start    (rd_start_q),
            .sda_in   (pins_q.sda),
            .sda_oe_n (sda_oe_n),
            .scl_oe_n (scl_oe_n),
            .done     (rd_done),
            .err      (rd_err),
            .desc     (rd_desc)
        );

        // rails: memory rail always on, sensor rails only when accepted
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                supply_q <= 1'b0;
                rail_q   <= 1'b1;
            end else begin
                supply_q <= (state_d == S_POWER) ||
                            (state_d == S_ACTIVE);
                rail_q   <= 1'b1;
            end
        end

        // reset stays low through the supply ramp
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                rst_n_q <= 1'b0;
            end else begin
                rst_n_q <= (state_d == S_ACTIVE);
            end
        end

        // card lamp is only ever pulled low, never driven high
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                lamp_oe_n_q <= 1'b1;
                low_q       <= 1'b0;
            end else begin
                lamp_oe_n_q <= (state_d != S_ACTIVE);
                low_q       <= 1'b0;
            end
        end

        // status flags for the lamp logic and the outside
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                rot_q   <= 1'b0;
                ready_q <= 1'b0;
            end else begin
                rot_q   <= (state_d == S_ROTATED);
                ready_q <= (state_d == S_ACTIVE);
            end
        end

        // card interrupt only means something once the card is active
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                irq_q <= 1'b0;
            end else begin
                irq_q <= ~pins_q.irq_n && (state_q == S_ACTIVE);
            end
        end

        // translator preset unless the controller takes over
        always_ff @(posedge REF_CLK or negedge RESET_N) begin
            if (!RESET_N) begin
                xen_q  <= 1'b1;
                xdir_q <= 1'b1;
            end else begin
                xen_q  <= XLAT_OVR[i] ? XLAT_EN_SET[i] : 1'b1;
                xdir_q <= XLAT_OVR[i] ? XLAT_DIR_SET[i] : 1'b1;
            end
        end

        assign IDM_SDA_O[i]        = low_q;
        assign IDM_SDA_OE_N[i]     = sda_oe_n;
        assign IDM_SCL_O[i]        = low_q;
        assign IDM_SCL_OE_N[i]     = scl_oe_n;
        assign CARD_LAMP_O[i]      = low_q;
        assign CARD_LAMP_OE_N[i]   = lamp_oe_n_q;
        assign SENSOR_IRQ[i]       = irq_q;
        assign SENSOR_RST_N[i]     = rst_n_q;
        assign SENSOR_SUPPLY_EN[i] = supply_q;
        assign IDMEM_RAIL_EN[i]    = rail_q;
        assign XLAT_EN[i]          = xen_q;
        assign XLAT_DIR[i]         = xdir_q;
        assign CARD_ROTATED[i]     = rot_q;
        assign CARD_READY[i]       = ready_q;
        assign rot_v[i]            = rot_q;
        assign ready_v[i]          = ready_q;
        assign busy_v[i]           = (state_q == S_SETTLE) ||
                                     (state_q == S_READ) ||
                                     (state_q == S_POWER);
    end

    // boot window lasts one settle time, so an empty board stops blinking
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            boot_q     <= 1'b1;
            boot_cnt_q <= 32'h0;
        end else if (boot_cnt_q == 32'(SETTLE_CYCLES - 1)) begin
            boot_q     <= 1'b0;
        end else begin
            boot_cnt_q <= boot_cnt_q + 32'h1;
        end
    end

    // free-running blink phase
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= ~blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    // error beats ready beats start-up blink
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rgb_q <= RGB_OFF;
        end else if (|rot_v) begin
            rgb_q <= RGB_RED;
        end else if (|ready_v) begin
            rgb_q <= RGB_GREEN;
        end else if (boot_q || (|busy_v)) begin
            rgb_q <= blink_q ? RGB_BLUE : RGB_OFF;
        end else begin
            rgb_q <= RGB_OFF;
        end
    end

    assign RGB_LAMP = rgb_q;
endmodule
`default_nettype wire

// [testbench/sensor_bringup_checker.sv]
// port assertions for the sensor bring-up sequencer
`default_nettype none
module sensor_bringup_checker
    import sensor_bringup_pkg::*;
#(parameter int NUM_SLOTS = 2) (
    input wire logic                 REF_CLK,          // clock
    input wire logic                 RESET_N,          // reset
    input wire logic [NUM_SLOTS-1:0] IDM_SCL_I,        // clock pin
    input wire logic [NUM_SLOTS-1:0] CARD_LAMP_I,      // lamp pin
    input wire logic [NUM_SLOTS-1:0] CARD_LAMP_OE_N,   // lamp pull
    input wire logic [NUM_SLOTS-1:0] SENSOR_RST_N,     // card reset
    input wire logic [NUM_SLOTS-1:0] SENSOR_SUPPLY_EN, // rails
    input wire logic [NUM_SLOTS-1:0] IDMEM_RAIL_EN,    // memory rail
    input wire logic [NUM_SLOTS-1:0] CARD_ROTATED,     // error
    input wire logic [NUM_SLOTS-1:0] CARD_READY,       // sensor up
    input wire rgb_t                 RGB_LAMP          // status
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    // sensor still held in reset; a removal during the ramp is legal
    sequence s_hold; !SENSOR_RST_N[0] && !CARD_READY[0]; endsequence
    // no pull-up seen on either line: slot 0 empty
    sequence s_gone; !IDM_SCL_I[0] && !CARD_LAMP_I[0]; endsequence
    property p_rail; IDMEM_RAIL_EN == '1; endproperty
    a_rail: assert property (p_rail) else $error("rail off");
    property p_lamp; CARD_LAMP_OE_N == ~CARD_READY; endproperty
    a_lamp: assert property (p_lamp) else $error("lamp");
    property p_rst; SENSOR_RST_N == CARD_READY; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_feed; (CARD_READY & ~SENSOR_SUPPLY_EN) == '0; endproperty
    a_feed: assert property (p_feed) else $error("feed");
    property p_red; |CARD_ROTATED |=> RGB_LAMP == RGB_RED; endproperty
    a_red: assert property (p_red) else $error("red");
    property p_green;
        !(|CARD_ROTATED) && |CARD_READY |=> RGB_LAMP == RGB_GREEN;
    endproperty
    a_green: assert property (p_green) else $error("green");
    property p_power;
        $rose(SENSOR_SUPPLY_EN[0]) |-> s_hold [*8] ##[1:6]
            (CARD_READY[0] || !SENSOR_SUPPLY_EN[0]);
    endproperty
    a_power: assert property (p_power) else $error("hold");
    property p_gone; s_gone [*4] |-> !SENSOR_SUPPLY_EN[0]; endproperty
    a_gone: assert property (p_gone) else $error("removal");
endmodule
bind sensor_bringup_sequencer sensor_bringup_checker
    #(.NUM_SLOTS(NUM_SLOTS)) sensor_bringup_checker_inst (.REF_CLK,
    .RESET_N, .IDM_SCL_I, .CARD_LAMP_I, .CARD_LAMP_OE_N, .SENSOR_RST_N,
    .SENSOR_SUPPLY_EN, .IDMEM_RAIL_EN, .CARD_ROTATED, .CARD_READY, .RGB_LAMP);
`default_nettype wire

// [testbench/card_model.sv]
// behavioural sensor card: pull-ups, id memory, interrupt
`default_nettype none
module card_model
    import sensor_bringup_pkg::*;
(
    input  wire logic [1:0]  mode,      // 0 none 1 fitted 2 rotated
    input  wire logic [15:0] desc,      // board, sensor bytes
    input  wire logic        irq,       // card wants service
    input  wire logic        sda_oe_n,  // host pulls data
    input  wire logic        scl_oe_n,  // host pulls clock
    input  wire logic        lamp_oe_n, // host pulls lamp
    output logic             sda,       // data level
    output logic             scl,       // clock level
    output logic             lamp,      // lamp level
    output logic             irq_n      // interrupt, low
);
    logic       slv_n = 1'b1;
    logic       act = 1'b0;
    logic       rd = 1'b0;
    logic       sda_p = 1'b0;
    logic       scl_p = 1'b0;
    logic [7:0] sh = 8'h00;
    logic [7:0] ptr = 8'h00;
    int         bitc = 0;
    int         n = 0;
    // base board pulls down; a rotated card pulls the lamp line instead
    assign scl = (mode == 2'd1) & scl_oe_n;
    assign sda = (mode == 2'd1) & sda_oe_n & slv_n;
    assign lamp = (mode != 2'd0) & lamp_oe_n;
    assign irq_n = ~(irq & (mode == 2'd1));
    // one process watches both lines, so each variable has one driver;
    // pulling the card drops both lines and must not look like a start
    always @(sda or scl) begin
        if (scl && scl_p && sda_p && !sda && mode == 2'd1) begin
            {act, bitc, n} = {1'b1, 64'd0};
        end else if (scl && scl_p && !sda_p && sda) begin
            act = 1'b0;
        end else if (scl && !scl_p && act) begin
            {sh, bitc} = {sh[6:0], sda, bitc + 1};
        end else if (!scl && scl_p && act) begin
            // next bit set up while the clock is low; released after nack
            if (bitc == 9) begin
                act = !(rd && n > 0 && sh[0]);
                ptr = ptr + 8'(rd && n > 0);
                {bitc, n} = {32'd0, n + 1};
            end else if (bitc == 8) begin
                rd = (n == 0) ? sh[0] : rd;
                ptr = (n > 0 && !rd) ? sh : ptr;
            end
            slv_n = !act ? 1'b1 : (bitc == 8) ? !((n == 0 && sh[7:1] ==
                IDMEM_ADDR) || (n > 0 && !rd)) : !(rd && n > 0) ? 1'b1 :
                ptr[0] ? desc[7 - bitc] : desc[15 - bitc];
        end
        {sda_p, scl_p} = {sda, scl};
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the sensor bring-up sequencer
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module tb
    import sensor_bringup_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic             clk = 0;
    logic             rst_n = 0;
    logic [1:0][1:0]  mode = '0;
    logic [1:0][15:0] desc = '0;
    logic [1:0]       irq = 0, ovr = 0, en_s = 0, dir_s = 0;
    wire logic [1:0]  sda, scl, lamp, irq_n, sda_oe_n, scl_oe_n, lamp_oe_n;
    wire logic [1:0]  sup, rst_o, rdy, rot, xen, xdir, irq_o;
    wire logic [5:0]  lo;
    rgb_t             rgb;
    int               miscompares = 0, checks_done = 0;
    // 25 MHz reference
    always #20 clk = ~clk;
    sensor_bringup_sequencer #(.SETTLE_CYCLES(20), .BLINK_CYCLES(8),
        .RST_HOLD_CYCLES(10), .QTR_CYCLES(2)) sensor_bringup_sequencer_inst (
        .REF_CLK(clk), .RESET_N(rst_n), .IDM_SDA_I(sda),
        .IDM_SDA_O(lo[1:0]), .IDM_SDA_OE_N(sda_oe_n), .IDM_SCL_I(scl),
        .IDM_SCL_O(lo[3:2]), .IDM_SCL_OE_N(scl_oe_n), .CARD_LAMP_I(lamp),
        .CARD_LAMP_O(lo[5:4]), .CARD_LAMP_OE_N(lamp_oe_n),
        .SENSOR_IRQ_N(irq_n), .SENSOR_IRQ(irq_o),
        .SENSOR_RST_N(rst_o), .SENSOR_SUPPLY_EN(sup), .IDMEM_RAIL_EN(),
        .XLAT_OVR(ovr), .XLAT_EN_SET(en_s), .XLAT_DIR_SET(dir_s),
        .XLAT_EN(xen), .XLAT_DIR(xdir), .CARD_ROTATED(rot),
        .CARD_READY(rdy), .RGB_LAMP(rgb));
    for (genvar i = 0; i < 2; i++) begin : g_card
        card_model card_model_inst (.mode(mode[i]), .desc(desc[i]),
            .irq(irq[i]), .sda_oe_n(sda_oe_n[i]), .scl_oe_n(scl_oe_n[i]),
            .lamp_oe_n(lamp_oe_n[i]), .sda(sda[i]), .scl(scl[i]),
            .lamp(lamp[i]), .irq_n(irq_n[i]));
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    // bounded wait on slot 0: ready (w=0) or rotated (w=1)
    task automatic wait0(int w);
        int k = 0;
        while ((w ? rot[0] : rdy[0]) !== 1'b1 && k++ < 3000)
            tick(1);
        if (k > 3000) begin
            miscompares++;
            summarize();
        end
    endtask
    // empty slots: lamp blinks, sensor rails off, translator at defaults
    task automatic t_boot();
        int t = 0;
        logic p = rgb.b;
        for (int k = 0; k < 18; k++) begin
            tick(1);
            t += int'(rgb.b != p);
            p = rgb.b;
        end
        `CHK(t > 0, 1'b1)
        `CHK({sup, rst_o}, 4'h0)
        `CHK({xen, xdir}, 4'hf)
    endtask
    // supported card in slot 0, unsupported sensor byte in slot 1
    task automatic t_pair();
        desc = {BOARD_TYPE_DEF, 8'h02, BOARD_TYPE_DEF, SENSOR_TYPE_DEF};
        mode = 4'h5;
        wait0(0);
        tick(60);
        `CHK({sup, rdy, rst_o}, 6'h15)
        `CHK(lamp_oe_n, 2'b10)
        `CHK(lo, 6'h00)
        `CHK(rgb, RGB_GREEN)
        irq = 2'b11;
        tick(4);
        `CHK(irq_o, 2'b01)
        irq = 2'b00;
        mode = 4'h4;
        tick(5);
        `CHK({sup, rdy}, 4'h0)
    endtask
    // card turned round in slot 0, slot 1 emptied
    task automatic t_rot();
        mode = 4'h2;
        wait0(1);
        tick(2);
        `CHK(rgb, RGB_RED)
        `CHK({sup, rot, lamp_oe_n}, 6'h07)
    endtask
    // override takes the set values, then falls back
    task automatic t_xlat();
        {ovr, en_s, dir_s} = 6'h36;
        tick(2);
        `CHK({xen, xdir}, 4'h6)
        ovr = 2'b00;
        tick(2);
        `CHK({xen, xdir}, 4'hf)
    endtask
    initial begin
        tick(6);
        rst_n = 1;
        t_boot();
        t_pair();
        t_rot();
        t_xlat();
        summarize();
    end
endmodule
`default_nettype wire
